// File: hdl/omc_regs.vh
// omc_regs.vh: register offsets, fields, reset values and timing counts
// assumes 32-bit AXI4-Lite words, byte addresses, 125 MHz aclk
`ifndef OMC_REGS_VH
`define OMC_REGS_VH

// ****************************************
// register byte offsets
// ****************************************
`define OMC_ADDR_CTRL_ONE 4'h0
`define OMC_ADDR_CTRL_TWO 4'h4
`define OMC_ADDR_TBASE 4'h8
`define OMC_ADDR_WAKE 4'hC

// ****************************************
// system_ctrl_reg_one fields
// ****************************************
`define OMC_C1_STOP 7
`define OMC_C1_RELM 6
`define OMC_C1_RETM 5
`define OMC_C1_OUTEN 4
`define OMC_C1_RESET 8'h00

// ****************************************
// system_ctrl_reg_two fields
// ****************************************
`define OMC_C2_XEN 7
`define OMC_C2_SLOW_OSC_ENABLE 6
`define OMC_C2_MAIN_CLOCK_SELECT 5
`define OMC_C2_IDLE 4
`define OMC_C2_GATE 2
`define OMC_C2_RESET 8'h80

// ****************************************
// time base / wake / power fields
// ****************************************
`define OMC_TB_EN 3
`define OMC_TB_IE 4
`define OMC_TB_IDLE_PWD 5
`define OMC_TB_STOP_PWD 6
`define OMC_TB_RESET 8'h00
`define OMC_WK_RESET 8'h00

// ****************************************
// timing counts (cycles of aclk)
// ****************************************
`define OMC_CYC_PER_MACHINE 4
`define OMC_WARMUP_CYCLES 16'h0400
`define OMC_SUPPLY_CYCLES 16'h0040

`endif

// File: hdl/omc_sync.v
// omc_sync.v: two-flop synchroniser for asynchronous pins
// assumes the input is a level from outside the aclk domain
`timescale 1ns/100ps
`default_nettype none
module omc_sync
(
	input wire aclk,
	input wire aresetn,
	input wire d,
	output reg q
);
	reg meta_q;
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end
		else
		begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

// File: hdl/omc_ctrl.v
// omc_ctrl.v: operating-mode controller with AXI4-Lite registers
// assumes pins and time-base clock are asynchronous and pass omc_sync
// How it works
// - reset lands in single-clock fast run
// - single clock: slow osc off, four-cycle machine
// - idle bit halts cpu, peripherals keep their clock
// - any interrupt releases single fast doze
// - master enable chooses service or continue
// - gate bit stops clocks until tick edge
// - tick doze ignores enable; irq needs three
// - tick enable at entry sets tick latch
// - dual clock: main clock from chosen osc
// - slow fast-on: select set, fast set
// - fast osc enable toggles slow variants
// - slow modes stop divider first stages
// - dual doze returns to dual fast run
// - slow doze stops fast osc, returns slow
// - slow doze fast-on keeps fast osc
// - slow tick doze returns fast-off slow run
// - stop turns oscillators off, holds state
// - stop pin edge/level or key wake releases
// - warm-up then resume after stop
// - idle power-down zero adds supply wait
// - stop power-down one adds supply wait
// - doze release clears idle bit
// - control two resets to fast only
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "omc_regs.vh"
module omc_ctrl
(
	input wire aclk,
	input wire aresetn,
	input wire [3:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [3:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire irq_any,
	input wire interrupt_master_enable,
	input wire time_base_clock_select,
	input wire stop_pin_n,
	input wire [3:0] key_wake,
	output reg fast_osc_on,
	output reg slow_osc_on,
	output reg main_clock_slow,
	output reg cpu_run,
	output reg periph_clk_en,
	output reg divider_low_en,
	output reg slow_pins_are_ports,
	output reg time_base_irq,
	output reg irq_service,
	output reg port_hold
);
	// ****************************************
	// modes
	// ****************************************
	localparam [3:0] FAST_RUN_SINGLE = 4'h0;
	localparam [3:0] FAST_RUN_DUAL = 4'h1;
	localparam [3:0] FAST_DOZE_SINGLE = 4'h2;
	localparam [3:0] FAST_DOZE_DUAL = 4'h3;
	localparam [3:0] TICK_DOZE_FAST = 4'h4;
	localparam [3:0] SLOW_RUN_FAST_ON = 4'h5;
	localparam [3:0] SLOW_RUN_FAST_OFF = 4'h6;
	localparam [3:0] SLOW_DOZE_FAST_ON = 4'h7;
	localparam [3:0] SLOW_DOZE_FAST_OFF = 4'h8;
	localparam [3:0] TICK_DOZE_SLOW = 4'h9;
	localparam [3:0] STOP_MODE = 4'hA;
	localparam [3:0] WARMUP = 4'hB;
	localparam [3:0] SUPPLY_WAIT = 4'hC;

	reg [7:0] system_ctrl_reg_one_q;
	reg [7:0] system_ctrl_reg_two_q;
	reg [7:0] time_base_ctrl_reg_q;
	reg [7:0] wakeup_release_ctrl_q;
	reg [3:0] mode_q;
	reg [3:0] resume_q;
	reg [15:0] wait_q;
	reg [1:0] phase_q;
	reg tick_pend_q;
	reg tb_prev_q;
	reg stop_prev_q;
	reg [3:0] aw_addr_q;
	reg aw_have_q;
	reg [31:0] w_data_q;
	reg [3:0] w_strb_q;
	reg w_have_q;

	wire tb_s;
	wire stop_s;
	wire [3:0] key_s;
	wire tick_fall;
	wire stop_release;
	wire at_boundary;
	wire do_write;

	// ****************************************
	// input synchronisers
	// ****************************************
	omc_sync u_tb (.aclk(aclk), .aresetn(aresetn), .d(time_base_clock_select), .q(tb_s));
	omc_sync u_stp (.aclk(aclk), .aresetn(aresetn), .d(stop_pin_n), .q(stop_s));
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1)
		begin : g_key
			omc_sync u_key (.aclk(aclk), .aresetn(aresetn), .d(key_wake[gi]), .q(key_s[gi]));
		end
	endgenerate

	assign tick_fall = tb_prev_q & ~tb_s;
	// edge mode wants a falling edge of the active-low pin; level mode wants it low
	assign stop_release = (system_ctrl_reg_one_q[`OMC_C1_RELM] ? ~stop_s :
		(stop_prev_q & ~stop_s)) | (|(key_s & wakeup_release_ctrl_q[3:0]));
	// mode changes only on a machine-cycle boundary
	assign at_boundary = (phase_q == 2'd3);
	assign do_write = aw_have_q & w_have_q & ~s_axi_bvalid;

	function [7:0] merge;
		input [7:0] old;
		input [31:0] data;
		input [3:0] strb;
		begin
			merge = strb[0] ? data[7:0] : old;
		end
	endfunction

	function is_doze;
		input [3:0] m;
		begin
			is_doze = (m == FAST_DOZE_SINGLE) | (m == FAST_DOZE_DUAL) |
				(m == TICK_DOZE_FAST) | (m == SLOW_DOZE_FAST_ON) |
				(m == SLOW_DOZE_FAST_OFF) | (m == TICK_DOZE_SLOW);
		end
	endfunction

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'b00;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'b00;
			s_axi_rdata <= 32'h00000000;
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 4'h0;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			s_axi_awready <= ~aw_have_q & ~s_axi_awready & s_axi_awvalid;
			s_axi_wready <= ~w_have_q & ~s_axi_wready & s_axi_wvalid;
			if (s_axi_awvalid & s_axi_awready)
			begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid & s_axi_wready)
			begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
			end
			else if (s_axi_bvalid & s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
			if (s_axi_arvalid & s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'b00;
				case (s_axi_araddr)
					`OMC_ADDR_CTRL_ONE: s_axi_rdata <= {24'h000000, system_ctrl_reg_one_q};
					`OMC_ADDR_CTRL_TWO: s_axi_rdata <= {24'h000000, system_ctrl_reg_two_q};
					`OMC_ADDR_TBASE: s_axi_rdata <= {24'h000000, time_base_ctrl_reg_q};
					`OMC_ADDR_WAKE: s_axi_rdata <= {24'h000000, mode_q, wakeup_release_ctrl_q[3:0]};
					default:
					begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= 2'b10;
					end
				endcase
			end
			else if (s_axi_rvalid & s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// mode sequencer and control registers
	// ****************************************
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			system_ctrl_reg_one_q <= `OMC_C1_RESET;
			system_ctrl_reg_two_q <= `OMC_C2_RESET;
			time_base_ctrl_reg_q <= `OMC_TB_RESET;
			wakeup_release_ctrl_q <= `OMC_WK_RESET;
			mode_q <= FAST_RUN_SINGLE;
			resume_q <= FAST_RUN_SINGLE;
			wait_q <= 16'h0000;
			phase_q <= 2'd0;
			tick_pend_q <= 1'b0;
			tb_prev_q <= 1'b0;
			stop_prev_q <= 1'b0;
			time_base_irq <= 1'b0;
			irq_service <= 1'b0;
		end
		else
		begin
			phase_q <= phase_q + 2'd1;
			// edges judged boundary to boundary so none slips between two boundaries;
			// a level that goes and returns between two boundaries is missed
			if (at_boundary)
			begin
				tb_prev_q <= tb_s;
				stop_prev_q <= stop_s;
			end
			irq_service <= 1'b0;
			time_base_irq <= 1'b0;
			if (do_write)
			begin
				case (aw_addr_q)
					`OMC_ADDR_CTRL_ONE: system_ctrl_reg_one_q <= merge(system_ctrl_reg_one_q, w_data_q, w_strb_q);
					`OMC_ADDR_CTRL_TWO: system_ctrl_reg_two_q <= merge(system_ctrl_reg_two_q, w_data_q, w_strb_q);
					`OMC_ADDR_TBASE: time_base_ctrl_reg_q <= merge(time_base_ctrl_reg_q, w_data_q, w_strb_q);
					`OMC_ADDR_WAKE: wakeup_release_ctrl_q <= merge(wakeup_release_ctrl_q, w_data_q, w_strb_q);
					default: ;
				endcase
			end
			if (at_boundary)
			begin
				case (mode_q)
					FAST_RUN_SINGLE, FAST_RUN_DUAL, SLOW_RUN_FAST_ON, SLOW_RUN_FAST_OFF:
					begin
						if (system_ctrl_reg_one_q[`OMC_C1_STOP])
						begin
							mode_q <= STOP_MODE;
							resume_q <= system_ctrl_reg_one_q[`OMC_C1_RETM] ? SLOW_RUN_FAST_OFF :
								(system_ctrl_reg_two_q[`OMC_C2_SLOW_OSC_ENABLE] ? FAST_RUN_DUAL : FAST_RUN_SINGLE);
						end
						else if (system_ctrl_reg_two_q[`OMC_C2_GATE])
						begin
							// tick enable sampled at entry
							tick_pend_q <= time_base_ctrl_reg_q[`OMC_TB_EN];
							mode_q <= system_ctrl_reg_two_q[`OMC_C2_MAIN_CLOCK_SELECT] ? TICK_DOZE_SLOW : TICK_DOZE_FAST;
						end
						else if (system_ctrl_reg_two_q[`OMC_C2_IDLE])
						begin
							case (mode_q)
								FAST_RUN_SINGLE: mode_q <= FAST_DOZE_SINGLE;
								FAST_RUN_DUAL: mode_q <= FAST_DOZE_DUAL;
								SLOW_RUN_FAST_ON: mode_q <= SLOW_DOZE_FAST_ON;
								default: mode_q <= SLOW_DOZE_FAST_OFF;
							endcase
						end
						// switch to the slow source only when the slow osc is enabled, glitch-free at boundary
						else if (system_ctrl_reg_two_q[`OMC_C2_MAIN_CLOCK_SELECT] & system_ctrl_reg_two_q[`OMC_C2_SLOW_OSC_ENABLE])
							mode_q <= system_ctrl_reg_two_q[`OMC_C2_XEN] ? SLOW_RUN_FAST_ON : SLOW_RUN_FAST_OFF;
						else if (system_ctrl_reg_two_q[`OMC_C2_XEN])
							mode_q <= system_ctrl_reg_two_q[`OMC_C2_SLOW_OSC_ENABLE] ? FAST_RUN_DUAL : FAST_RUN_SINGLE;
					end
					FAST_DOZE_SINGLE, FAST_DOZE_DUAL, SLOW_DOZE_FAST_ON, SLOW_DOZE_FAST_OFF:
					begin
						if (irq_any)
						begin
							system_ctrl_reg_two_q[`OMC_C2_IDLE] <= 1'b0;
							irq_service <= interrupt_master_enable;
							resume_q <= (mode_q == FAST_DOZE_SINGLE) ? FAST_RUN_SINGLE :
								(mode_q == FAST_DOZE_DUAL) ? FAST_RUN_DUAL : mode_q - 4'd2;
							wait_q <= `OMC_SUPPLY_CYCLES;
							mode_q <= time_base_ctrl_reg_q[`OMC_TB_IDLE_PWD] ?
								((mode_q == FAST_DOZE_SINGLE) ? FAST_RUN_SINGLE :
								(mode_q == FAST_DOZE_DUAL) ? FAST_RUN_DUAL : mode_q - 4'd2) : SUPPLY_WAIT;
						end
					end
					TICK_DOZE_FAST, TICK_DOZE_SLOW:
					begin
						if (tick_fall)
						begin
							system_ctrl_reg_two_q[`OMC_C2_GATE] <= 1'b0;
							resume_q <= (mode_q == TICK_DOZE_FAST) ? FAST_RUN_SINGLE : SLOW_RUN_FAST_OFF;
							wait_q <= `OMC_SUPPLY_CYCLES;
							if (time_base_ctrl_reg_q[`OMC_TB_IDLE_PWD])
								mode_q <= (mode_q == TICK_DOZE_FAST) ? FAST_RUN_SINGLE : SLOW_RUN_FAST_OFF;
							else
								mode_q <= SUPPLY_WAIT;
						end
					end
					STOP_MODE:
					begin
						if (stop_release)
						begin
							system_ctrl_reg_one_q[`OMC_C1_STOP] <= 1'b0;
							wait_q <= `OMC_WARMUP_CYCLES;
							mode_q <= WARMUP;
						end
					end
					WARMUP:
					begin
						if (wait_q == 16'h0000)
						begin
							wait_q <= `OMC_SUPPLY_CYCLES;
							mode_q <= time_base_ctrl_reg_q[`OMC_TB_STOP_PWD] ? SUPPLY_WAIT : resume_q;
						end
					end
					SUPPLY_WAIT:
					begin
						if (wait_q == 16'h0000)
							mode_q <= resume_q;
					end
					default: mode_q <= FAST_RUN_SINGLE;
				endcase
			end
			// latch pulse one cycle after the return, once the run-mode clocks are back
			if (tick_pend_q && (mode_q == FAST_RUN_SINGLE || mode_q == SLOW_RUN_FAST_OFF))
			begin
				time_base_irq <= 1'b1;
				irq_service <= interrupt_master_enable & time_base_ctrl_reg_q[`OMC_TB_IE];
				tick_pend_q <= 1'b0;
			end
			if ((mode_q == WARMUP || mode_q == SUPPLY_WAIT) && wait_q != 16'h0000)
				wait_q <= wait_q - 16'h0001;
		end
	end

	// ****************************************
	// clock and power outputs
	// ****************************************
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fast_osc_on <= 1'b1;
			slow_osc_on <= 1'b0;
			main_clock_slow <= 1'b0;
			cpu_run <= 1'b1;
			periph_clk_en <= 1'b1;
			divider_low_en <= 1'b1;
			slow_pins_are_ports <= 1'b1;
			port_hold <= 1'b0;
		end
		else
		begin
			fast_osc_on <= ~(mode_q == STOP_MODE || mode_q == SLOW_RUN_FAST_OFF ||
				mode_q == SLOW_DOZE_FAST_OFF || mode_q == TICK_DOZE_SLOW);
			slow_osc_on <= system_ctrl_reg_two_q[`OMC_C2_SLOW_OSC_ENABLE] & (mode_q != STOP_MODE);
			slow_pins_are_ports <= ~system_ctrl_reg_two_q[`OMC_C2_SLOW_OSC_ENABLE];
			main_clock_slow <= (mode_q >= SLOW_RUN_FAST_ON) && (mode_q <= TICK_DOZE_SLOW);
			cpu_run <= ~is_doze(mode_q) && mode_q != STOP_MODE && mode_q != WARMUP &&
				mode_q != SUPPLY_WAIT;
			periph_clk_en <= mode_q != TICK_DOZE_FAST && mode_q != TICK_DOZE_SLOW &&
				mode_q != STOP_MODE;
			divider_low_en <= ~((mode_q >= SLOW_RUN_FAST_ON) && (mode_q <= TICK_DOZE_SLOW)) &&
				mode_q != STOP_MODE;
			port_hold <= (mode_q == STOP_MODE) & system_ctrl_reg_one_q[`OMC_C1_OUTEN];
		end
	end
endmodule
`default_nettype wire

// File: sim/omc_ctrl_props.sv
// omc_ctrl_props.sv: assertions on the mode outputs of omc_ctrl
// assumes it is bound to omc_ctrl, one aclk domain, sync active-low reset
`timescale 1ns/100ps
`default_nettype none
module omc_ctrl_props
(
	input wire aclk,
	input wire aresetn,
	input wire irq_any,
	input wire interrupt_master_enable,
	input wire time_base_clock_select,
	input wire fast_osc_on,
	input wire slow_osc_on,
	input wire main_clock_slow,
	input wire cpu_run,
	input wire periph_clk_en,
	input wire divider_low_en,
	input wire time_base_irq,
	input wire irq_service
);
	// ****************
	// mode checks
	// ****************
	default clocking dc @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	reset_state_a: assert property (
		!$past(aresetn) |-> fast_osc_on && !slow_osc_on && cpu_run && !main_clock_slow)
		else $error("state after reset wrong");
	fast_main_a: assert property (
		cpu_run && !main_clock_slow |-> fast_osc_on)
		else $error("fast main clock without fast osc");
	slow_main_a: assert property (
		cpu_run && main_clock_slow |-> slow_osc_on)
		else $error("slow main clock without slow osc");
	divider_stop_a: assert property (
		$rose(main_clock_slow) |-> ##[0:6] !divider_low_en)
		else $error("divider low stages run in slow mode");
	doze_release_a: assert property (
		!cpu_run && periph_clk_en && irq_any |-> ##[1:120] cpu_run)
		else $error("doze not left on interrupt");
	service_gate_a: assert property (
		irq_service |-> interrupt_master_enable)
		else $error("interrupt served while masked");
	service_pulse_a: assert property (
		irq_service |=> !irq_service)
		else $error("service pulse too long");
	tick_release_a: assert property (
		!periph_clk_en && $fell(time_base_clock_select) |-> ##[1:120] periph_clk_en)
		else $error("tick doze not left on time base edge");
	tick_latch_a: assert property (
		time_base_irq |-> periph_clk_en)
		else $error("tick latch set before return");
	stop_halt_a: assert property (
		!fast_osc_on && !slow_osc_on |-> !cpu_run)
		else $error("cpu runs with both oscillators off");
	cover property (!cpu_run && irq_any ##1 cpu_run);
	cover property (time_base_irq);
	cover property (!fast_osc_on && !slow_osc_on ##1 fast_osc_on);
endmodule
`default_nettype wire

// File: sim/omc_ctrl_bench.sv
// omc_ctrl_bench.sv: self-checking bench for the operating-mode controller
// assumes omc_ctrl and omc_regs.vh from hdl/, aclk at 125 MHz
`timescale 1ns/100ps
`default_nettype none
`include "omc_regs.vh"
`define CHK(a, b) \
	begin \
	compares++; \
	if ((a) !== (b)) \
	$display("mismatch at %0t: %h vs %h", $time, (a), (b)); \
	if ((a) !== (b)) \
	n_fail++; \
	end
module omc_ctrl_bench;
	localparam int CPU = 0;
	localparam int PER = 1;
	localparam int FST = 2;
	localparam int SLW = 3;
	localparam int PRT = 4;
	localparam int DIV = 5;
	localparam int TBI = 6;
	logic aclk = 1'b0;
	logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [3:0] s_axi_awaddr, s_axi_araddr, key_wake;
	logic [31:0] s_axi_wdata;
	logic irq_any, time_base_clock_select, stop_pin_n, interrupt_master_enable;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire fast_osc_on, slow_osc_on, main_clock_slow, cpu_run, periph_clk_en;
	wire divider_low_en, slow_pins_are_ports, time_base_irq, irq_service, port_hold;
	wire [6:0] obs;
	int n_fail = 0;
	int compares = 0;
	int n_svc = 0;
	assign obs = {time_base_irq, divider_low_en, slow_pins_are_ports, main_clock_slow,
		fast_osc_on, periph_clk_en, cpu_run};
	always #4 aclk = ~aclk;
	// one-cycle service pulses are counted, scenarios compare the count
	always @(posedge aclk)
		if (irq_service === 1'b1)
			n_svc++;
	omc_ctrl u_dut
	(
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .irq_any(irq_any),
		.interrupt_master_enable(interrupt_master_enable),
		.time_base_clock_select(time_base_clock_select), .stop_pin_n(stop_pin_n),
		.key_wake(key_wake), .fast_osc_on(fast_osc_on), .slow_osc_on(slow_osc_on),
		.main_clock_slow(main_clock_slow), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
		.divider_low_en(divider_low_en), .slow_pins_are_ports(slow_pins_are_ports),
		.time_base_irq(time_base_irq), .irq_service(irq_service), .port_hold(port_hold)
	);
	// ****************
	// shared tasks
	// ****************
	task automatic wrap_up();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a wait that runs out ends the run at once
	task automatic bound(input int n, input int lim);
		`CHK(n < lim, 1'b1)
		if (n >= lim)
			wrap_up();
	endtask
	task automatic await(input int s, input logic v, output int n);
		for (n = 0; n < 3000 && obs[s] !== v; n++)
			@(negedge aclk);
		bound(n, 3000);
	endtask
	task automatic axi_wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_bvalid; n++)
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		bound(n, 50);
		`CHK(s_axi_bresp, er)
	endtask
	task automatic axi_rd(input logic [3:0] a, input logic [7:0] e);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50 && !s_axi_rvalid; n++)
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		bound(n, 50);
		`CHK(s_axi_rdata, {24'h000000, e})
		`CHK(s_axi_rresp, (a[1:0] == 2'b00) ? 2'b00 : 2'b10)
	endtask
	// ****************
	// scenarios
	// ****************
	task automatic t_reset();
		@(negedge aclk);
		`CHK({slow_osc_on, obs}, 8'h37)
		axi_rd(4'h4, 8'h80);
		axi_rd(4'h0, 8'h00);
		axi_rd(4'hC, 8'h00);
	endtask
	// doze from the run mode set by c2, dz is the expected doze mode read-back
	task automatic t_doze(input logic ime, input logic [7:0] c2, input logic [7:0] dz);
		int n;
		int s0;
		axi_wr(4'h8, 8'h00, 2'b00);
		interrupt_master_enable <= ime;
		axi_wr(4'h4, c2 | 8'h10, 2'b00);
		await(CPU, 1'b0, n);
		`CHK({fast_osc_on, periph_clk_en}, {c2[7], 1'b1})
		axi_rd(4'hC, dz);
		s0 = n_svc;
		@(posedge aclk);
		irq_any <= 1'b1;
		await(CPU, 1'b1, n);
		`CHK(n >= `OMC_SUPPLY_CYCLES, 1'b1)
		`CHK(n_svc - s0, ime ? 1 : 0)
		@(posedge aclk);
		irq_any <= 1'b0;
		axi_rd(4'h4, c2);
	endtask
	task automatic t_tick();
		int n;
		int s0;
		s0 = n_svc;
		axi_wr(4'h8, 8'h38, 2'b00);
		axi_wr(4'h4, 8'h84, 2'b00);
		await(PER, 1'b0, n);
		`CHK(cpu_run, 1'b0)
		@(posedge aclk);
		time_base_clock_select <= 1'b0;
		await(TBI, 1'b1, n);
		`CHK(periph_clk_en, 1'b1)
		@(posedge aclk);
		time_base_clock_select <= 1'b1;
		axi_rd(4'h4, 8'h80);
		`CHK(n_svc - s0, 1)
	endtask
	task automatic t_slow();
		int n;
		axi_wr(4'h4, 8'hC0, 2'b00);
		await(PRT, 1'b0, n);
		`CHK(slow_osc_on, 1'b1)
		axi_wr(4'h4, 8'hE0, 2'b00);
		await(SLW, 1'b1, n);
		await(DIV, 1'b0, n);
		axi_wr(4'h4, 8'h60, 2'b00);
		await(FST, 1'b0, n);
		axi_rd(4'hC, 8'h60);
		t_doze(1'b1, 8'h60, 8'h80);
		axi_wr(4'h4, 8'hE0, 2'b00);
		await(FST, 1'b1, n);
		axi_rd(4'hC, 8'h50);
		t_doze(1'b1, 8'hE0, 8'h70);
		axi_wr(4'h4, 8'hC0, 2'b00);
		await(SLW, 1'b0, n);
		t_doze(1'b1, 8'hC0, 8'h30);
		axi_wr(4'h4, 8'h80, 2'b00);
		await(PRT, 1'b1, n);
	endtask
	// key release is tried in level mode, pin release is tried edge-triggered
	task automatic t_stop(input logic key, input logic [7:0] c, input logic [7:0] tb);
		int n;
		axi_wr(4'h8, tb, 2'b00);
		axi_wr(4'hC, 8'h01, 2'b00);
		axi_wr(4'h0, c, 2'b00);
		await(FST, 1'b0, n);
		`CHK({cpu_run, slow_osc_on}, 2'b00)
		`CHK(port_hold, c[4])
		@(posedge aclk);
		key_wake <= {3'b000, key};
		stop_pin_n <= key;
		await(CPU, 1'b1, n);
		`CHK(n >= `OMC_WARMUP_CYCLES + (tb[6] ? `OMC_SUPPLY_CYCLES : 16'h0000), 1'b1)
		@(posedge aclk);
		key_wake <= 4'h0;
		stop_pin_n <= 1'b1;
		axi_rd(4'h0, c & 8'h7F);
	endtask
	initial
	begin
		aresetn <= 1'b0;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		s_axi_bready <= 1'b0;
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b0;
		s_axi_awaddr <= 4'h0;
		s_axi_araddr <= 4'h0;
		s_axi_wdata <= 32'h00000000;
		key_wake <= 4'h0;
		irq_any <= 1'b0;
		interrupt_master_enable <= 1'b1;
		time_base_clock_select <= 1'b1;
		stop_pin_n <= 1'b1;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_doze(1'b0, 8'h80, 8'h20);
		t_doze(1'b1, 8'h80, 8'h20);
		t_tick();
		t_slow();
		t_stop(1'b0, 8'h90, 8'h40);
		t_stop(1'b1, 8'hC0, 8'h00);
		axi_wr(4'h1, 8'h55, 2'b10);
		axi_rd(4'h0, 8'h40);
		axi_rd(4'h2, 8'h00);
		wrap_up();
	end
endmodule
bind omc_ctrl omc_ctrl_props u_props
(
	.aclk(aclk), .aresetn(aresetn), .irq_any(irq_any),
	.interrupt_master_enable(interrupt_master_enable),
	.time_base_clock_select(time_base_clock_select), .fast_osc_on(fast_osc_on),
	.slow_osc_on(slow_osc_on), .main_clock_slow(main_clock_slow), .cpu_run(cpu_run),
	.periph_clk_en(periph_clk_en), .divider_low_en(divider_low_en),
	.time_base_irq(time_base_irq), .irq_service(irq_service)
);
`default_nettype wire
